// File: design/debug_frame_pkg.sv
// Purpose: Shared constants and types for the debug line command frame engine
// Assumes: Bytes arrive already deframed from the serial debug line
// Notes:   Check byte polynomial and seed are plain defaults, the line format leaves them open

package debug_frame_pkg;

   // ----------------------------------------------------------------
   // Command bytes and nibbles
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_RD_PC    = 8'h06;
   localparam logic [7:0] CMD_WR_PC    = 8'h07;
   localparam logic [7:0] CMD_RD_FLAGS = 8'h08;
   localparam logic [7:0] CMD_WR_INSTR = 8'h09;
   localparam logic [3:0] NIB_RD_REG   = 4'h4;
   localparam logic [3:0] NIB_WR_REG   = 4'h5;
   localparam logic [7:0] PAD_BYTE     = 8'h00;

   // ----------------------------------------------------------------
   // Operand and answer lengths in bytes
   // ----------------------------------------------------------------
   localparam logic [2:0] LEN_RD_PC    = 3'h4;
   localparam logic [2:0] LEN_WR_PC    = 3'h4;
   localparam logic [2:0] LEN_RD_FLAGS = 3'h2;
   localparam logic [2:0] LEN_WR_INSTR = 3'h2;
   localparam logic [2:0] LEN_REG      = 3'h4;
   localparam logic [2:0] LEN_LAST     = 3'h1;
   localparam logic [2:0] LEN_NONE     = 3'h0;

   // ----------------------------------------------------------------
   // Check byte defaults
   // ----------------------------------------------------------------
   localparam logic [7:0] CRC_POLY_DEF = 8'h07;
   localparam logic [7:0] CRC_INIT_DEF = 8'h00;

   // Frame engine states
   typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_RX, ST_TX, ST_CRC} state_t;

endpackage

// File: design/debug_frame_crc.sv
// Purpose: Byte-wide running check byte over one command frame
// Assumes: One byte folded in per enabled clock
// Notes:   Start reseeds and folds the first byte in the same cycle

`timescale 1ns/1ps
`default_nettype none

module debug_frame_crc
#(
   parameter logic [7:0] CRC_POLY = debug_frame_pkg::CRC_POLY_DEF,
   parameter logic [7:0] CRC_INIT = debug_frame_pkg::CRC_INIT_DEF
)
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Byte feed
   input  wire logic       start,
   input  wire logic       enable,
   input  wire logic [7:0] data_byte,
   // Running value
   output logic      [7:0] crc_value
);

   logic [7:0] crc_reg;
   logic [7:0] crc_next;
   logic [7:0] crc_base;

   // Seed select: a new frame never inherits the old remainder
   assign crc_base  = start ? CRC_INIT : crc_reg;
   assign crc_value = crc_reg;

   // Bitwise MSB-first division, unrolled by the loop
   always_comb
   begin
      crc_next = crc_base ^ data_byte;
      for (int i = 0; i < 8; i++)
      begin
         crc_next = crc_next[7] ? ({crc_next[6:0], 1'b0} ^ CRC_POLY) : {crc_next[6:0], 1'b0};
      end
   end

   // Remainder register
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         crc_reg <= 8'h00;
      else if (enable)
         crc_reg <= crc_next;
   end

endmodule // debug_frame_crc

`default_nettype wire

// File: design/debug_serial_command_frames.sv
// Purpose: Command frame engine behind the debug_line byte receiver and transmitter
// Assumes: rx_valid marks one received byte; tx_ready accepts a held tx byte
// Notes:   Half duplex, bytes received while answering are dropped
//
// Operation
// RL1: PC read 06h answers pad 00h, counter bytes 23:16..7:0, then check byte.
// RL2: PC write 07h takes pad 00h then three counter bytes MSB first; check byte.
// RL3: Flags read 08h answers pad 00h, flags byte, then check byte.
// RL4: Instruction write 09h takes opcode high then low byte; check byte.
// RL5: Register write value bytes arrive high to low; frame closes with check byte.
// RL6: Register read 4xh answers 32-bit value MSB first, then check byte.
// RL7: Register write 5xh takes four value bytes MSB first, then check byte.
// RL8: Check byte covers whole frame; unknown command bytes are ignored.

`timescale 1ns/1ps
`default_nettype none

module debug_serial_command_frames
#(
   parameter logic [7:0] CRC_POLY = debug_frame_pkg::CRC_POLY_DEF,
   parameter logic [7:0] CRC_INIT = debug_frame_pkg::CRC_INIT_DEF
)
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Received bytes from debug_line
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_byte,
   // Bytes to transmit on debug_line
   output logic             tx_valid,
   output logic [7:0]       tx_byte,
   input  wire logic        tx_ready,
   // CPU state taps
   input  wire logic [23:0] program_counter,
   input  wire logic [7:0]  cpu_flags,
   // Program counter load
   output logic             pc_wr_en,
   output logic [23:0]      pc_wr_data,
   // Instruction injection
   output logic             instr_valid,
   output logic [15:0]      instr_opcode,
   // Register file port
   output logic [3:0]       reg_idx,
   input  wire logic [31:0] reg_rd_data,
   output logic             reg_wr_en,
   output logic [31:0]      reg_wr_data
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   debug_frame_pkg::state_t state_reg, state_next;
   logic [2:0]  cnt_reg, cnt_next;
   logic [31:0] shift_reg, shift_next;
   logic [7:0]  cmd_reg, cmd_next;
   logic        tx_valid_reg, tx_valid_next;
   logic [7:0]  tx_byte_reg, tx_byte_next;
   logic        pc_wr_en_reg, pc_wr_en_next;
   logic [23:0] pc_wr_data_reg, pc_wr_data_next;
   logic        instr_valid_reg, instr_valid_next;
   logic [15:0] instr_opcode_reg, instr_opcode_next;
   logic [3:0]  reg_idx_reg, reg_idx_next;
   logic        reg_wr_en_reg, reg_wr_en_next;
   logic [31:0] reg_wr_data_reg, reg_wr_data_next;
   logic        crc_start, crc_en, crc_src_tx;
   logic [7:0]  crc_value;

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   wire is_rd_pc    = (rx_byte == debug_frame_pkg::CMD_RD_PC);
   wire is_wr_pc    = (rx_byte == debug_frame_pkg::CMD_WR_PC);
   wire is_rd_flags = (rx_byte == debug_frame_pkg::CMD_RD_FLAGS);
   wire is_wr_instr = (rx_byte == debug_frame_pkg::CMD_WR_INSTR);
   wire is_rd_reg   = (rx_byte[7:4] == debug_frame_pkg::NIB_RD_REG);
   wire is_wr_reg   = (rx_byte[7:4] == debug_frame_pkg::NIB_WR_REG);
   wire is_known    = is_rd_pc | is_wr_pc | is_rd_flags | is_wr_instr | is_rd_reg | is_wr_reg;
   wire tx_free     = !tx_valid_reg || tx_ready;     // Slot free or being emptied
   wire last_rx     = rx_valid && (cnt_reg == debug_frame_pkg::LEN_LAST);
   wire [7:0] crc_byte = crc_src_tx ? shift_reg[31:24] : rx_byte;
   wire [31:0] rx_word = {shift_reg[23:0], rx_byte};

   // Running check byte; fed by host bytes and by our own answer bytes
   debug_frame_crc
   #(
      .CRC_POLY (CRC_POLY),
      .CRC_INIT (CRC_INIT)
   )
   u_crc
   (
      .mclk      (mclk),
      .rst       (rst),
      .start     (crc_start),
      .enable    (crc_en),
      .data_byte (crc_byte),
      .crc_value (crc_value)
   );

   // ----------------------------------------------------------------
   // Frame sequencer
   // ----------------------------------------------------------------
   // Next-state logic; pulses default low so each lasts one cycle
   always_comb
   begin
      state_next        = state_reg;
      cnt_next          = cnt_reg;
      shift_next        = shift_reg;
      cmd_next          = cmd_reg;
      tx_valid_next     = tx_valid_reg;
      tx_byte_next      = tx_byte_reg;
      pc_wr_en_next     = 1'b0;
      pc_wr_data_next   = pc_wr_data_reg;
      instr_valid_next  = 1'b0;
      instr_opcode_next = instr_opcode_reg;
      reg_idx_next      = reg_idx_reg;
      reg_wr_en_next    = 1'b0;
      reg_wr_data_next  = reg_wr_data_reg;
      crc_start         = 1'b0;
      crc_en            = 1'b0;
      crc_src_tx        = 1'b0;
      case (state_reg)
         debug_frame_pkg::ST_IDLE:
         begin
            // RL8: unknown bytes dropped
            if (rx_valid && is_known)
            begin
               crc_start = 1'b1;
               crc_en    = 1'b1;
               cmd_next  = rx_byte;
               // RL1: snapshot counter
               if (is_rd_pc)
               begin
                  shift_next = {debug_frame_pkg::PAD_BYTE, program_counter};
                  cnt_next   = debug_frame_pkg::LEN_RD_PC;
                  state_next = debug_frame_pkg::ST_TX;
               end
               // RL3: snapshot flags
               else if (is_rd_flags)
               begin
                  shift_next = {debug_frame_pkg::PAD_BYTE, cpu_flags, 16'h0000};
                  cnt_next   = debug_frame_pkg::LEN_RD_FLAGS;
                  state_next = debug_frame_pkg::ST_TX;
               end
               // RL6: index to register port
               else if (is_rd_reg)
               begin
                  reg_idx_next = rx_byte[3:0];
                  state_next   = debug_frame_pkg::ST_FETCH;
               end
               else
               begin
                  reg_idx_next = is_wr_reg ? rx_byte[3:0] : reg_idx_reg;
                  cnt_next     = is_wr_instr ? debug_frame_pkg::LEN_WR_INSTR : debug_frame_pkg::LEN_REG;
                  state_next   = debug_frame_pkg::ST_RX;
               end
            end
         end
         debug_frame_pkg::ST_FETCH:
         begin
            // Register port read data is taken one cycle after the index
            shift_next = reg_rd_data;
            cnt_next   = debug_frame_pkg::LEN_REG;
            state_next = debug_frame_pkg::ST_TX;
         end
         debug_frame_pkg::ST_RX:
         begin
            if (rx_valid)
            begin
               crc_en     = 1'b1;
               shift_next = rx_word;
               cnt_next   = cnt_reg - 3'h1;
               if (last_rx)
               begin
                  state_next = debug_frame_pkg::ST_TX;
                  // RL2: pad byte discarded
                  if (cmd_reg == debug_frame_pkg::CMD_WR_PC)
                  begin
                     pc_wr_en_next   = 1'b1;
                     pc_wr_data_next = rx_word[23:0];
                  end
                  // RL4: high byte first
                  else if (cmd_reg == debug_frame_pkg::CMD_WR_INSTR)
                  begin
                     instr_valid_next  = 1'b1;
                     instr_opcode_next = rx_word[15:0];
                  end
                  // RL7: four bytes MSB first
                  else
                  begin
                     reg_wr_en_next   = 1'b1;
                     reg_wr_data_next = rx_word;
                  end
               end
            end
         end
         debug_frame_pkg::ST_TX:
         begin
            if (tx_free)
            begin
               tx_valid_next = 1'b1;
               if (cnt_reg != debug_frame_pkg::LEN_NONE)
               begin
                  crc_en       = 1'b1;
                  crc_src_tx   = 1'b1;
                  tx_byte_next = shift_reg[31:24];
                  shift_next   = {shift_reg[23:0], 8'h00};
                  cnt_next     = cnt_reg - 3'h1;
               end
               // RL5: close frame with check byte
               else
               begin
                  tx_byte_next = crc_value;
                  state_next   = debug_frame_pkg::ST_CRC;
               end
            end
         end
         debug_frame_pkg::ST_CRC:
         begin
            if (tx_ready)
            begin
               tx_valid_next = 1'b0;
               state_next    = debug_frame_pkg::ST_IDLE;
            end
         end
         default:
         begin
            state_next = debug_frame_pkg::ST_IDLE;
         end
      endcase
   end

   // Control registers
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_reg    <= debug_frame_pkg::ST_IDLE;
         cnt_reg      <= 3'h0;
         cmd_reg      <= 8'h00;
         tx_valid_reg <= 1'b0;
         pc_wr_en_reg <= 1'b0;
         instr_valid_reg <= 1'b0;
         reg_wr_en_reg   <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         cmd_reg      <= cmd_next;
         tx_valid_reg <= tx_valid_next;
         pc_wr_en_reg <= pc_wr_en_next;
         instr_valid_reg <= instr_valid_next;
         reg_wr_en_reg   <= reg_wr_en_next;
      end
   end

   // Data registers
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         shift_reg        <= 32'h0000_0000;
         tx_byte_reg      <= 8'h00;
         pc_wr_data_reg   <= 24'h00_0000;
         instr_opcode_reg <= 16'h0000;
         reg_idx_reg      <= 4'h0;
         reg_wr_data_reg  <= 32'h0000_0000;
      end
      else
      begin
         shift_reg        <= shift_next;
         tx_byte_reg      <= tx_byte_next;
         pc_wr_data_reg   <= pc_wr_data_next;
         instr_opcode_reg <= instr_opcode_next;
         reg_idx_reg      <= reg_idx_next;
         reg_wr_data_reg  <= reg_wr_data_next;
      end
   end

   // Outputs straight from flops
   assign tx_valid     = tx_valid_reg;
   assign tx_byte      = tx_byte_reg;
   assign pc_wr_en     = pc_wr_en_reg;
   assign pc_wr_data   = pc_wr_data_reg;
   assign instr_valid  = instr_valid_reg;
   assign instr_opcode = instr_opcode_reg;
   assign reg_idx      = reg_idx_reg;
   assign reg_wr_en    = reg_wr_en_reg;
   assign reg_wr_data  = reg_wr_data_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   wire idle_cmd = (state_reg == debug_frame_pkg::ST_IDLE) && rx_valid;

   a_pc_read_load: assert property (idle_cmd && is_rd_pc |=> // RL1
      shift_reg == {8'h00, $past(program_counter)} && cnt_reg == 3'h4 && state_reg == debug_frame_pkg::ST_TX)
      else $error("pc read frame not loaded");
   a_pc_write_pulse: assert property (pc_wr_en_reg |-> // RL2
      $past(state_reg == debug_frame_pkg::ST_RX && cmd_reg == 8'h07 && last_rx) ##1 !pc_wr_en_reg)
      else $error("pc write pulse wrong");
   a_flags_read_load: assert property (idle_cmd && is_rd_flags |=> // RL3
      shift_reg[31:16] == {8'h00, $past(cpu_flags)} && cnt_reg == 3'h2)
      else $error("flags read frame not loaded");
   a_instr_byte_order: assert property (instr_valid_reg |-> // RL4
      instr_opcode_reg == {$past(shift_reg[7:0]), $past(rx_byte)})
      else $error("opcode byte order wrong");
   a_check_byte_sent: assert property (state_reg == debug_frame_pkg::ST_CRC |-> // RL5
      tx_valid_reg && tx_byte_reg == crc_value)
      else $error("check byte mismatch");
   a_reg_read_fetch: assert property (state_reg == debug_frame_pkg::ST_FETCH |=> // RL6
      shift_reg == $past(reg_rd_data) && cnt_reg == 3'h4 && reg_idx_reg == $past(reg_idx_reg))
      else $error("register read not fetched");
   a_reg_write_data: assert property (reg_wr_en_reg |-> // RL7
      reg_wr_data_reg == {$past(shift_reg[23:0]), $past(rx_byte)} && $past(cmd_reg[7:4]) == 4'h5)
      else $error("register write data wrong");
   a_unknown_ignored: assert property (idle_cmd && !is_known |=> // RL8
      state_reg == debug_frame_pkg::ST_IDLE && !tx_valid_reg && cmd_reg == $past(cmd_reg))
      else $error("unknown command not ignored");
   a_tx_hold_stall: assert property (tx_valid_reg && !tx_ready |=>
      tx_valid_reg && $stable(tx_byte_reg))
      else $error("tx byte dropped under stall");

   c_pc_read: cover property (idle_cmd && is_rd_pc ##[1:40] state_reg == debug_frame_pkg::ST_CRC && tx_ready);
   c_pc_write: cover property (pc_wr_en_reg);
   c_instr_write: cover property (instr_valid_reg);
   c_reg_read: cover property (state_reg == debug_frame_pkg::ST_FETCH);
   c_reg_write_stall: cover property (reg_wr_en_reg ##[1:4] tx_valid_reg && !tx_ready);

endmodule // debug_serial_command_frames

`default_nettype wire

// File: tb/debug_host_model.sv
// Purpose: Host adapter side of the debug_line byte stream, takes answer bytes
// Assumes: slow selects a pseudo random stall pattern on tx_ready
// Notes:   Stalls are bounded because the shift register never reaches zero

`timescale 1ns/1ps
`default_nettype none

module debug_host_model
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // Answer byte handshake
   input  wire logic tx_valid,
   input  wire logic slow,
   output logic      tx_ready
);
   logic [7:0] lfsr_reg;

   // Stall pattern, moves every cycle so stalls land in all frame phases
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         lfsr_reg <= 8'h5B;
      else
         lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
   end

   assign tx_ready = slow ? (tx_valid & lfsr_reg[0] & lfsr_reg[2]) : 1'b1; // Prompt or slow host
endmodule // debug_host_model

`default_nettype wire

// File: tb/debug_serial_command_frames_bench.sv
// Purpose: Self-checking bench for the debug_line command frame engine
// Assumes: Default check byte polynomial and seed
// Notes:   Expected bytes and write pulses share one queue, kept in arrival order

`timescale 1ns/1ps
`default_nettype none

module debug_serial_command_frames_bench;
   logic mclk, rst, rx_valid, tx_valid, tx_ready, slow, pc_wr_en, instr_valid, reg_wr_en;
   logic [7:0]  rx_byte, tx_byte, cpu_flags;
   logic [23:0] program_counter, pc_wr_data;
   logic [15:0] instr_opcode;
   logic [3:0]  reg_idx;
   logic [31:0] reg_rd_data, reg_wr_data;
   logic [31:0] reg_file [16];
   logic [39:0] exp_q [$];
   int          num_errors, cmp_count;
   integer      seed = 32'hacd124d0;

   debug_serial_command_frames dut_u (.mclk(mclk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .program_counter(program_counter),
      .cpu_flags(cpu_flags), .pc_wr_en(pc_wr_en), .pc_wr_data(pc_wr_data), .instr_valid(instr_valid),
      .instr_opcode(instr_opcode), .reg_idx(reg_idx), .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en),
      .reg_wr_data(reg_wr_data));
   debug_host_model host_u (.mclk(mclk), .rst(rst), .tx_valid(tx_valid), .slow(slow), .tx_ready(tx_ready));

   // Register file answers at once, so fetch timing never hides a stale value
   assign reg_rd_data = reg_file[reg_idx];

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic pop_chk(input logic [39:0] seen);
      if (exp_q.size() == 0)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected nothing %h", $time, seen, 40'h0);
      end
      else
         chk(seen, exp_q.pop_front());
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   function automatic logic [7:0] crc8(input logic [7:0] c_in, input logic [7:0] b);
      logic [7:0] c;
      c = c_in ^ b;
      for (int k = 0; k < 8; k++)
         c = c[7] ? ((c << 1) ^ debug_frame_pkg::CRC_POLY_DEF) : (c << 1);
      return c;
   endfunction

   // Monitor, every accepted byte or write pulse retires the oldest note
   always @(posedge mclk)
   begin
      if (!rst && tx_valid && tx_ready)
         pop_chk({4'h0, 4'h0, 24'h0, tx_byte});
      if (!rst && pc_wr_en)
         pop_chk({4'h1, 4'h0, 8'h0, pc_wr_data});
      if (!rst && instr_valid)
         pop_chk({4'h2, 4'h0, 16'h0, instr_opcode});
      if (!rst && reg_wr_en)
         pop_chk({4'h3, reg_idx, reg_wr_data});
   end

   // One command frame, back to back bytes, optional junk while answering
   task automatic frame(input logic [7:0] cmd, input int nops, input logic [31:0] ops, input int nans,
                        input logic [39:0] ans, input logic has_wr, input logic [39:0] wr_ev,
                        input logic junk);
      logic [7:0]  c;
      logic [7:0]  b;
      logic [31:0] r;
      int          t;
      c = crc8(debug_frame_pkg::CRC_INIT_DEF, cmd);
      for (int i = 0; i < nops; i++)
         c = crc8(c, ops[8*(nops-1-i) +: 8]);
      for (int i = 0; i < nans; i++)
      begin
         b = ans[8*(nans-1-i) +: 8];
         c = crc8(c, b);
         exp_q.push_back({16'h0, 16'h0, b});
      end
      if (has_wr)
         exp_q.push_back(wr_ev);
      exp_q.push_back({32'h0, c});
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_byte  <= cmd;
      for (int i = 0; i < nops; i++)
      begin
         @(posedge mclk);
         rx_byte <= ops[8*(nops-1-i) +: 8];
      end
      @(posedge mclk);
      r = $random(seed);
      rx_valid        <= 1'b0;
      rx_byte         <= ~rx_byte;
      program_counter <= r[23:0]; // Live values move, answer must keep the sampled ones
      cpu_flags       <= r[31:24];
      // Junk lands while the answer is still being sent; later it could reach an idle engine
      if (junk)
      begin
         @(posedge mclk);
         rx_valid <= 1'b1;
         rx_byte  <= debug_frame_pkg::CMD_WR_PC;
         @(posedge mclk);
         rx_byte  <= 8'h4A;
         @(posedge mclk);
         rx_valid <= 1'b0;
         rx_byte  <= 8'hB5;
      end
      t = 0;
      while (exp_q.size() != 0 && t < 300)
      begin
         @(posedge mclk);
         t++;
      end
      if (exp_q.size() != 0)
      begin
         num_errors++;
         $display("Frame %h timed out", cmd);
         end_of_test();
      end
   endtask

   initial
   begin
      logic [31:0] r, wv;
      logic [23:0] pcv;
      logic [15:0] op;
      logic [7:0]  u;
      logic [3:0]  idx;
      rst = 1'b1;
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      slow = 1'b0;
      program_counter = 24'h0;
      cpu_flags = 8'h00;
      for (int i = 0; i < 16; i++)
         reg_file[i] = $random(seed);
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk(40'({tx_valid, tx_byte, pc_wr_en, instr_valid, reg_wr_en, reg_idx}), 40'h0);
      chk(40'({pc_wr_data, instr_opcode}), 40'h0);
      for (int it = 0; it < 6; it++)
      begin
         r = $random(seed);
         @(posedge mclk);
         slow <= it[0];
         program_counter <= r[23:0];
         cpu_flags <= r[31:24];
         for (int j = 0; j < 4; j++)
         begin
            u = $random(seed);
            if (u[7:4] == debug_frame_pkg::NIB_RD_REG || u[7:4] == debug_frame_pkg::NIB_WR_REG ||
                (u >= debug_frame_pkg::CMD_RD_PC && u <= debug_frame_pkg::CMD_WR_INSTR))
               u = u ^ 8'h80;
            @(posedge mclk);
            rx_valid <= 1'b1;
            rx_byte <= u;
         end
         @(posedge mclk);
         rx_valid <= 1'b0;
         repeat (20) @(posedge mclk);
         chk(40'(exp_q.size()), 40'h0);
         $display("Test unknown commands done");
         r = $random(seed);
         pcv = r[23:0];
         op = r[31:16];
         wv = $random(seed);
         idx = (it == 0) ? 4'h0 : (it == 1) ? 4'hF : r[3:0];
         frame(debug_frame_pkg::CMD_RD_PC, 0, 32'h0, 4,
               {8'h00, debug_frame_pkg::PAD_BYTE, program_counter}, 1'b0, 40'h0, slow);
         frame(debug_frame_pkg::CMD_WR_PC, 4, {debug_frame_pkg::PAD_BYTE, pcv}, 0, 40'h0,
               1'b1, {4'h1, 4'h0, 8'h0, pcv}, 1'b0);
         frame(debug_frame_pkg::CMD_RD_FLAGS, 0, 32'h0, 2,
               {24'h0, debug_frame_pkg::PAD_BYTE, cpu_flags}, 1'b0, 40'h0, slow);
         frame(debug_frame_pkg::CMD_WR_INSTR, 2, {16'h0, op}, 0, 40'h0, 1'b1, {4'h2, 4'h0, 16'h0, op}, 1'b0);
         frame({debug_frame_pkg::NIB_RD_REG, idx}, 0, 32'h0, 4, {8'h0, reg_file[idx]}, 1'b0, 40'h0, slow);
         frame({debug_frame_pkg::NIB_WR_REG, idx}, 4, wv, 0, 40'h0, 1'b1, {4'h3, idx, wv}, 1'b0);
         $display("Test frame round %0d done", it);
      end
      end_of_test();
   end
endmodule // debug_serial_command_frames_bench

`default_nettype wire
